// >>> fsp_status_guard.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_status_guard
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               resetn,
   // Serial link pins
   input  wire logic               csN,
   input  wire logic               sck,
   input  wire logic               si,
   input  wire logic               wpN,
   input  wire logic               holdN,
   // Serial data out
   output logic                    soOut,
   output logic                    soOeN,
   // Quad data ports for the protect and hold pins, held at their reset values
   output logic                    io2Out,
   output logic                    io2OeN,
   output logic                    io3Out,
   output logic                    io3OeN,
   // Configuration seen by the rest of the device
   output logic                    quadMode,
   output var fsp_pkg::fsp_drive_e driveSel
);

   logic       rstMeta;
   logic       rstSyncN;
   fsp_pins_s  pinsAsync;
   fsp_pins_s  pinsSync;
   logic       sckRise;
   logic       sckFall;
   logic       csRise;

   logic [11:0] bitCount, next_bitCount;
   logic [23:0] shiftIn, next_shiftIn;
   logic [7:0]  opcode, next_opcode;
   logic [23:0] addr, next_addr;
   fsp_sr1_s    sr1, next_sr1;
   fsp_sr2_s    sr2, next_sr2;
   logic [7:0]  sr3, next_sr3;
   fsp_op_e     opState, next_opState;
   logic [11:0] opTimer, next_opTimer;
   logic [7:0]  outShift, next_outShift;
   logic        next_soOut;
   logic        next_soOeN;

   logic        busyFlag;
   logic        wpLevel;
   logic        holdActive;
   logic        srLocked;
   logic        suspended;
   logic        isRead;
   logic        isSrWrite;
   logic [11:0] cntInc;
   logic [7:0]  snap;
   logic        secLocked;
   fsp_sr1_s    dataSr1;
   fsp_sr2_s    dataSr2;

   // Async assert, release through two flip-flops.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   always_comb begin
      pinsAsync = {csN, sck, si, wpN, holdN};
   end

   fsp_pin_sync u_sync (
      .clk       (clk),
      .rstN      (rstSyncN),
      .pinsAsync (pinsAsync),
      .pinsSync  (pinsSync),
      .sckRise   (sckRise),
      .sckFall   (sckFall),
      .csRise    (csRise)
   );

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      suspended  = sr2.eraseSuspendedFlag | sr2.programSuspendedFlag;
      busyFlag   = (opState != OP_IDLE) && !suspended; // RULE14
      // In quad mode the protect pin carries data, so it no longer guards.
      wpLevel    = sr2.quadIoEnable | pinsSync.wpN; // RULE18
      holdActive = !sr2.quadIoEnable && !pinsSync.holdN; // RULE18
      case ({sr2.statusLockBit1, sr1.statusLockBit0})
         2'h0:    srLocked = 1'b0; // RULE1
         2'h1:    srLocked = !wpLevel; // RULE2 RULE3
         default: srLocked = 1'b1; // RULE4
      endcase
      isRead    = (opcode == CMD_READ_SR1) || (opcode == CMD_READ_SR2)
                  || (opcode == CMD_READ_SR3);
      isSrWrite = (opcode == CMD_WRITE_SR1) || (opcode == CMD_WRITE_SR2)
                  || (opcode == CMD_WRITE_SR3);
      cntInc    = bitCount + 12'h001;
      dataSr1   = shiftIn[7:0];
      dataSr2   = shiftIn[7:0];
      if (addr[SEC_PAGE_LSB +: 2] == 2'h3) begin
         secLocked = 1'b1;
      end else begin
         secLocked = sr2.securityPageLock[addr[SEC_PAGE_LSB +: 2]]; // RULE15
      end
      // Each byte is a fresh snapshot so polling sees the flag fall.
      if (opcode == CMD_READ_SR2) begin
         snap = sr2;
      end else if (opcode == CMD_READ_SR3) begin
         snap = sr3; // RULE24
      end else begin
         snap = {sr1[7:1], busyFlag}; // RULE14
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_bitCount = bitCount;
      next_shiftIn  = shiftIn;
      next_opcode   = opcode;
      next_addr     = addr;
      next_sr1      = sr1;
      next_sr2      = sr2;
      next_sr3      = sr3;
      next_opState  = opState;
      next_opTimer  = opTimer;
      next_outShift = outShift;
      next_soOut    = soOut;
      next_soOeN    = soOeN;

      if (busyFlag) begin
         next_opTimer = opTimer - 12'h001;
         if (opTimer == TIMER_LAST) begin
            next_opState              = OP_IDLE; // RULE21
            next_sr1.writeEnableLatch = 1'b0; // RULE12 RULE21
         end
      end

      if (pinsSync.csN) begin
         next_bitCount = 12'h000;
         next_soOeN    = 1'b1;
      end else if (sckRise && !holdActive) begin
         next_shiftIn = {shiftIn[22:0], pinsSync.si};
         if (bitCount != BIT_MAX) begin
            next_bitCount = cntInc;
         end
         if (cntInc == BIT_OPCODE) begin
            next_opcode = {shiftIn[6:0], pinsSync.si};
         end
         if (cntInc == BIT_ADDR) begin
            next_addr = {shiftIn[22:0], pinsSync.si};
         end
      end else if (sckFall && !holdActive && isRead && bitCount >= BIT_OPCODE) begin
         next_soOeN = 1'b0;
         if (bitCount[2:0] == 3'h0) begin
            next_soOut    = snap[7]; // RULE14
            next_outShift = {snap[6:0], 1'b0};
         end else begin
            next_soOut    = outShift[7];
            next_outShift = {outShift[6:0], 1'b0};
         end
      end

      // A frame shorter than an opcode does nothing at all.
      if (csRise && bitCount >= BIT_OPCODE && !busyFlag) begin // RULE13
         case (opcode)
            CMD_WRITE_ENABLE: begin
               if (bitCount == BIT_OPCODE) begin
                  next_sr1.writeEnableLatch = 1'b1;
               end
            end
            CMD_WRITE_DISABLE: begin
               if (bitCount == BIT_OPCODE) begin
                  next_sr1.writeEnableLatch = 1'b0; // RULE12
               end
            end
            CMD_WRITE_SR1, CMD_WRITE_SR2, CMD_WRITE_SR3: begin
               next_sr1.writeEnableLatch = 1'b0; // RULE10 RULE12
               if (sr1.writeEnableLatch && bitCount == BIT_SRDATA && !srLocked
                   && !suspended) begin // RULE20 RULE22
                  next_opState = OP_SRWRITE; // RULE20
                  next_opTimer = SRWRITE_CYCLES;
                  next_sr1.writeEnableLatch = 1'b1;
                  if (opcode == CMD_WRITE_SR1) begin // RULE26
                     next_sr1.statusLockBit0 = dataSr1.statusLockBit0; // RULE23
                     next_sr1.blockProtect   = dataSr1.blockProtect;
                  end else if (opcode == CMD_WRITE_SR2) begin // RULE26
                     next_sr2.complementProtect = dataSr2.complementProtect; // RULE23
                     next_sr2.securityPageLock  = sr2.securityPageLock
                                                  | dataSr2.securityPageLock;
                     next_sr2.quadIoEnable      = dataSr2.quadIoEnable;
                     next_sr2.statusLockBit1    = dataSr2.statusLockBit1;
                  end else begin
                     next_sr3 = shiftIn[7:0]; // RULE24
                  end
               end
            end
            CMD_PAGE_PROGRAM, CMD_SEC_PROGRAM: begin
               next_sr1.writeEnableLatch = 1'b0; // RULE10 RULE12
               if (sr1.writeEnableLatch && !suspended && bitCount >= BIT_PROGMIN
                   && bitCount[2:0] == 3'h0
                   && !((opcode == CMD_SEC_PROGRAM) ? secLocked // RULE15
                        : protectHit(addr, sr1.blockProtect, sr2.complementProtect))) begin
                  next_opState = OP_PROGRAM;
                  next_opTimer = PROGRAM_CYCLES;
                  next_sr1.writeEnableLatch = 1'b1;
               end
            end
            CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K, CMD_SEC_ERASE: begin
               next_sr1.writeEnableLatch = 1'b0; // RULE10 RULE12
               if (sr1.writeEnableLatch && !suspended && bitCount == BIT_ADDR
                   && !((opcode == CMD_SEC_ERASE) ? secLocked // RULE15
                        : protectHit(addr, sr1.blockProtect, sr2.complementProtect))) begin
                  next_opState = OP_ERASE;
                  next_opTimer = ERASE_CYCLES;
                  next_sr1.writeEnableLatch = 1'b1;
               end
            end
            CMD_CHIP_ERASE, CMD_CHIP_ERASE_B: begin
               next_sr1.writeEnableLatch = 1'b0; // RULE10 RULE12
               // Any protected region at all refuses the whole-array erase.
               if (sr1.writeEnableLatch && !suspended && bitCount == BIT_OPCODE
                   && !sr2.complementProtect && sr1.blockProtect[2:0] == 3'h0) begin
                  next_opState = OP_ERASE;
                  next_opTimer = ERASE_CYCLES;
                  next_sr1.writeEnableLatch = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      if (csRise && bitCount == BIT_OPCODE) begin
         // A suspend in the last busy cycle loses to completion, so no stale flag is left.
         if (opcode == CMD_SUSPEND && busyFlag && opTimer != TIMER_LAST) begin
            next_sr2.eraseSuspendedFlag   = (opState == OP_ERASE); // RULE16
            next_sr2.programSuspendedFlag = (opState != OP_ERASE); // RULE17
         end else if (opcode == CMD_RESUME) begin
            next_sr2.eraseSuspendedFlag   = 1'b0; // RULE16
            next_sr2.programSuspendedFlag = 1'b0; // RULE17
         end
      end
   end

   // Reset models a power cycle, so a lockdown code always returns to 00.
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         bitCount <= 12'h000;
         shiftIn  <= 24'h000000;
         opcode   <= 8'h00;
         addr     <= 24'h000000;
         sr1      <= SR1_RESET; // RULE5 RULE11
         sr2      <= SR2_RESET; // RULE5
         sr3      <= SR3_RESET;
         opState  <= OP_IDLE;
         opTimer  <= 12'h000;
         outShift <= 8'h00;
         soOut    <= 1'b0;
         soOeN    <= 1'b1;
         io2Out   <= 1'b0;
         io2OeN   <= 1'b1;
         io3Out   <= 1'b0;
         io3OeN   <= 1'b1;
         quadMode <= 1'b0;
         driveSel <= DRIVE_FULL;
      end else begin
         bitCount <= next_bitCount;
         shiftIn  <= next_shiftIn;
         opcode   <= next_opcode;
         addr     <= next_addr;
         sr1      <= next_sr1;
         sr2      <= next_sr2;
         sr3      <= next_sr3;
         opState  <= next_opState;
         opTimer  <= next_opTimer;
         outShift <= next_outShift;
         soOut    <= next_soOut;
         soOeN    <= next_soOeN;
         quadMode <= sr2.quadIoEnable; // RULE18
         driveSel <= driveDecode(sr3[6:5]); // RULE25
      end
   end

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSyncN);

   a_lock_refuse: assert property ( // RULE2
      csRise && isSrWrite && !sr2.statusLockBit1 && sr1.statusLockBit0 && !wpLevel
      && opState == OP_IDLE
      |=> opState == OP_IDLE && sr3 == $past(sr3)
      && sr1.blockProtect == $past(sr1.blockProtect))
      else $error("status write taken while pin-locked");
   a_lockdown_keep: assert property ( // RULE4
      sr2.statusLockBit1 && !sr1.statusLockBit0
      |=> sr2.statusLockBit1 && !sr1.statusLockBit0)
      else $error("supply lockdown code changed");
   a_latch_needed: assert property ( // RULE10
      csRise && !sr1.writeEnableLatch && opState == OP_IDLE |=> opState == OP_IDLE)
      else $error("operation started without the latch");
   a_short_keeps: assert property ( // RULE13
      csRise && bitCount < BIT_OPCODE && !busyFlag
      |=> sr1.writeEnableLatch == $past(sr1.writeEnableLatch))
      else $error("latch changed by an incomplete opcode");
   a_cycle_end: assert property ( // RULE21
      opState == OP_SRWRITE && busyFlag && opTimer == TIMER_LAST
      |=> opState == OP_IDLE && !sr1.writeEnableLatch)
      else $error("status cycle end did not clear latch");
   a_busy_shown: assert property ( // RULE14
      opState == OP_IDLE ##1 opState != OP_IDLE |-> busyFlag [*2])
      else $error("busy flag not raised by a new operation");
   a_erase_suspend: assert property ( // RULE16
      csRise && opcode == CMD_SUSPEND && bitCount == BIT_OPCODE && busyFlag
      && opState == OP_ERASE && opTimer != TIMER_LAST |=> sr2.eraseSuspendedFlag && !busyFlag)
      else $error("erase suspend not flagged");
   a_prog_resume: assert property ( // RULE17
      csRise && opcode == CMD_RESUME && bitCount == BIT_OPCODE
      |=> !sr2.programSuspendedFlag ##1 !sr2.programSuspendedFlag || csRise)
      else $error("resume did not clear program suspend");
   a_byte_bound: assert property ( // RULE20
      csRise && isSrWrite && bitCount != BIT_SRDATA && bitCount >= BIT_OPCODE && !busyFlag
      |=> opState == $past(opState) && !sr1.writeEnableLatch)
      else $error("status write taken off the byte boundary");

   c_sr_write: cover property (csRise && isSrWrite ##1 opState == OP_SRWRITE);
   c_suspend:  cover property (sr2.eraseSuspendedFlag ##[1:1000] !sr2.eraseSuspendedFlag);
   c_poll:     cover property (!soOeN && busyFlag ##[1:1000] !busyFlag);

endmodule : fsp_status_guard
`default_nettype wire

// >>> fsp_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) Lock bits 00: write allowed when latch set.
// (RULE2) Lock bits 01, protect pin low: locked.
// (RULE3) Lock bits 01, protect pin high: writable.
// (RULE4) Lock bits 10: locked until power cycle.
// (RULE5) Power cycle returns lockdown code to 00.
// (RULE6) Complement bit swaps protected and unprotected regions.
// (RULE7) Block bit 4 picks small or large granularity.
// (RULE8) Block bit 3 picks top or bottom start.
// (RULE9) Block bits 2..0 set protected size.
// (RULE10) Latch clear rejects program, erase, status writes.
// (RULE11) Latch clears on power-up and reset.
// (RULE12) Latch clears after disable, completion or abort.
// (RULE13) Incomplete opcode abort keeps the latch.
// (RULE14) Busy flag high during operation, status refreshed.
// (RULE15) Security page lock bits refuse program, erase.
// (RULE16) Suspend sets, resume clears erase suspended flag.
// (RULE17) Suspend sets, resume clears program suspended flag.
// (RULE18) Quad enable turns hold, protect into data; the code only drops their hold and protect roles, io2/io3 never drive.
// (RULE19) Host sets latch before status writes.
// (RULE20) Chip select must rise after data byte.
// (RULE21) Write in progress during cycle, latch clears after.
// (RULE22) Hardware protected state ignores status writes.
// (RULE23) Status writes change only read-write bits.
// (RULE24) Third status register written 11h, read 15h.
// (RULE25) Drive field: 11 auto, 10 half, 01 three-quarter.
// (RULE26) 01h loads first, 31h loads second register.
//////////////////////////////////////////////////////////////////////////////
package fsp_pkg;

   localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_READ_SR1      = 8'h05;
   localparam logic [7:0] CMD_READ_SR2      = 8'h35;
   localparam logic [7:0] CMD_READ_SR3      = 8'h15;
   localparam logic [7:0] CMD_WRITE_SR1     = 8'h01;
   localparam logic [7:0] CMD_WRITE_SR2     = 8'h31;
   localparam logic [7:0] CMD_WRITE_SR3     = 8'h11;
   localparam logic [7:0] CMD_SUSPEND       = 8'h75;
   localparam logic [7:0] CMD_RESUME        = 8'h7A;
   localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] CMD_SEC_PROGRAM   = 8'h42;
   localparam logic [7:0] CMD_SEC_ERASE     = 8'h44;
   localparam logic [7:0] CMD_ERASE_4K      = 8'h20;
   localparam logic [7:0] CMD_ERASE_32K     = 8'h52;
   localparam logic [7:0] CMD_ERASE_64K     = 8'hD8;
   localparam logic [7:0] CMD_CHIP_ERASE    = 8'hC7;
   localparam logic [7:0] CMD_CHIP_ERASE_B  = 8'h60;

   localparam logic [11:0] BIT_OPCODE  = 12'h008;
   localparam logic [11:0] BIT_SRDATA  = 12'h010;
   localparam logic [11:0] BIT_ADDR    = 12'h020;
   localparam logic [11:0] BIT_PROGMIN = 12'h028;
   localparam logic [11:0] BIT_MAX     = 12'hFFF;

   localparam logic [11:0] SRWRITE_CYCLES = 12'h7D0;
   localparam logic [11:0] PROGRAM_CYCLES = 12'h7D0;
   localparam logic [11:0] ERASE_CYCLES   = 12'hFA0;
   localparam logic [11:0] TIMER_LAST     = 12'h001;

   localparam logic [23:0] ARRAY_BYTES = 24'h800000;
   localparam logic [23:0] SMALL_BLOCK = 24'h001000;
   localparam logic [23:0] LARGE_BLOCK = 24'h010000;
   localparam int          SEC_PAGE_LSB = 12;

   typedef struct packed {
      logic       statusLockBit0;
      logic [4:0] blockProtect;
      logic       writeEnableLatch;
      logic       readyBusyFlag;
   } fsp_sr1_s;

   typedef struct packed {
      logic       eraseSuspendedFlag;
      logic       complementProtect;
      logic [2:0] securityPageLock;
      logic       programSuspendedFlag;
      logic       quadIoEnable;
      logic       statusLockBit1;
   } fsp_sr2_s;

   typedef struct packed {
      logic csN;
      logic sck;
      logic si;
      logic wpN;
      logic holdN;
   } fsp_pins_s;

   typedef enum logic [1:0] {OP_IDLE, OP_SRWRITE, OP_PROGRAM, OP_ERASE} fsp_op_e;
   typedef enum logic [1:0] {DRIVE_FULL, DRIVE_THREE_QUARTER, DRIVE_HALF, DRIVE_AUTO} fsp_drive_e;

   localparam fsp_sr1_s  SR1_RESET = 8'h00;
   localparam fsp_sr2_s  SR2_RESET = 8'h00;
   localparam logic [7:0] SR3_RESET = 8'h60;
   localparam fsp_pins_s PINS_IDLE = 5'h13;

   // Region decode; the complement bit flips the result for every address.
   function automatic logic protectHit(input logic [23:0] addr, input logic [4:0] bp,
                                       input logic cmp);
      logic [23:0] len;
      logic        inRegion;
      len = 24'h000000;
      if (bp[2:0] != 3'h0) begin
         len = (bp[4] ? SMALL_BLOCK : LARGE_BLOCK) << (bp[2:0] - 3'h1); // RULE7 RULE9
      end
      inRegion = bp[3] ? (addr < len) : (addr >= ARRAY_BYTES - len); // RULE8
      if (len == 24'h000000) begin
         inRegion = 1'b0;
      end
      return inRegion ^ cmp; // RULE6
   endfunction : protectHit

   function automatic fsp_drive_e driveDecode(input logic [1:0] drv);
      fsp_drive_e sel;
      case (drv) // RULE25
         2'h3:    sel = DRIVE_AUTO;
         2'h2:    sel = DRIVE_HALF;
         2'h1:    sel = DRIVE_THREE_QUARTER;
         default: sel = DRIVE_FULL;
      endcase
      return sel;
   endfunction : driveDecode

endpackage : fsp_pkg

// >>> fsp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_pin_sync
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rstN,
   // Pins from the link
   input  wire fsp_pkg::fsp_pins_s pinsAsync,
   // Synchronised view and edges
   output var fsp_pkg::fsp_pins_s pinsSync,
   output logic                 sckRise,
   output logic                 sckFall,
   output logic                 csRise
);

   fsp_pins_s stage1;
   fsp_pins_s stage2;
   logic      sckLast;
   logic      csLast;

   // Edges look only at the second stage and later, never the first.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stage1  <= PINS_IDLE;
         stage2  <= PINS_IDLE;
         sckLast <= 1'b0;
         csLast  <= 1'b1;
      end else begin
         stage1  <= pinsAsync;
         stage2  <= stage1;
         sckLast <= stage2.sck;
         csLast  <= stage2.csN;
      end
   end

   always_comb begin
      pinsSync = stage2;
      sckRise  = stage2.sck & ~sckLast;
      sckFall  = ~stage2.sck & sckLast;
      csRise   = stage2.csN & ~csLast;
   end

endmodule : fsp_pin_sync
`default_nettype wire

// >>> fsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_host_model (
   // Clock
   input  wire logic clk,
   // From the device
   input  wire logic soOut,
   input  wire logic soOeN,
   // To the device
   output var logic  csN,
   output var logic  sck,
   output var logic  si
);
   logic [7:0] rxByte;

   initial begin
      csN    = 1'b1;
      sck    = 1'b0;
      si     = 1'b0;
      rxByte = 8'h00;
   end

   //////////////////////////////////////////////////////////////////////////
   // Shifts n bits of d, MSB first, with a 200 ns serial clock.
   // The sample is taken before each rise, so a bit that is not driven reads as unknown.
   task automatic xfer(input logic [39:0] d, input int n);
      @(posedge clk);
      csN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         si <= d[39-i];
         repeat (2) @(posedge clk);
         rxByte <= {rxByte[6:0], (soOeN ? 1'bx : soOut)};
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         sck <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (2) @(posedge clk);
      csN <= 1'b1;
      si  <= ~si;
      repeat (6) @(posedge clk);
   endtask : xfer
endmodule : fsp_host_model
`default_nettype wire

// >>> fsp_status_guard_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_status_guard_bench;
   import fsp_pkg::*;
   logic       clk;
   logic       resetn;
   logic       wpN;
   wire logic  csN;
   wire logic  sck;
   wire logic  si;
   logic       soOut;
   logic       soOeN;
   logic       io2OeN;
   logic       io2Out, io3Out, io3OeN;
   logic       quadMode;
   fsp_drive_e driveSel;
   int         badCount;
   int         checks;
   fsp_drive_e drvExp [4] = '{DRIVE_FULL, DRIVE_THREE_QUARTER, DRIVE_HALF, DRIVE_AUTO};

   fsp_status_guard dut (.clk(clk), .resetn(resetn), .csN(csN), .sck(sck), .si(si),
      .wpN(wpN), .holdN(1'b1), .soOut(soOut), .soOeN(soOeN), .io2Out(io2Out), .io2OeN(io2OeN),
      .io3Out(io3Out), .io3OeN(io3OeN), .quadMode(quadMode), .driveSel(driveSel));
   fsp_host_model host (.clk(clk), .soOut(soOut), .soOeN(soOeN), .csN(csN), .sck(sck),
      .si(si));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   //////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finishTest;
      $display("Checks %0d, mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finishTest

   task automatic doReset;
      resetn <= 1'b0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : doReset

   task automatic rd(input logic [7:0] op, output logic [7:0] v);
      host.xfer({op, 32'h0}, 16);
      v = host.rxByte;
   endtask : rd

   // Polls until ready; a hang ends the run with a mismatch.
   task automatic waitIdle;
      logic [7:0] v;
      int         n;
      n = 0;
      v = 8'h01;
      while (v[0] !== 1'b0) begin
         n++;
         if (n > 40) begin
            badCount++;
            $display("MISMATCH at %0t: device stayed busy", $time);
            finishTest();
         end
         rd(CMD_READ_SR1, v);
      end
   endtask : waitIdle

   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
      host.xfer({op, d, 24'h0}, 16);
      waitIdle();
   endtask : wr

   initial begin
      repeat (100000) @(posedge clk);
      badCount++;
      $display("MISMATCH at %0t: run limit reached", $time);
      finishTest();
   end

   //////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      resetn   = 1'b0;
      wpN      = 1'b1;
      badCount = 0;
      checks   = 0;
      doReset();
      rd(CMD_READ_SR1, v); check(v, 8'h00);
      rd(CMD_READ_SR3, v); check(v, SR3_RESET);
      host.xfer({CMD_WRITE_SR1, 8'hFC, 24'h0}, 16);
      waitIdle();
      rd(CMD_READ_SR1, v); check(v, 8'h00);
      host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
      rd(CMD_READ_SR1, v); check(v, 8'h02);
      host.xfer({CMD_WRITE_SR1, 32'h0}, 4);
      rd(CMD_READ_SR1, v); check(v, 8'h02);
      host.xfer({CMD_WRITE_DISABLE, 32'h0}, 8);
      rd(CMD_READ_SR1, v); check(v, 8'h00);
      host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
      host.xfer({CMD_WRITE_SR1, 8'hFF, 24'h0}, 16);
      rd(CMD_READ_SR1, v); check({6'h0, v[1:0]}, 8'h03);
      waitIdle();
      rd(CMD_READ_SR1, v); check(v, 8'hFC);
      wpN <= 1'b0;
      wr(CMD_WRITE_SR1, 8'h00);
      rd(CMD_READ_SR1, v); check(v, 8'hFC);
      wpN <= 1'b1;
      wr(CMD_WRITE_SR1, 8'h04);
      rd(CMD_READ_SR1, v); check(v, 8'h04);
      host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
      host.xfer({CMD_WRITE_SR1, 32'h0}, 12);
      rd(CMD_READ_SR1, v); check(v, 8'h04);
      for (int k = 0; k < 4; k++) begin
         wr(CMD_WRITE_SR3, {1'b0, 2'(k), 5'h00});
         rd(CMD_READ_SR3, v); check(v, {1'b0, 2'(k), 5'h00});
         check({6'h0, driveSel}, {6'h0, drvExp[k]});
      end
      wr(CMD_WRITE_SR2, 8'h42);
      rd(CMD_READ_SR2, v); check(v, 8'h42);
      check({6'h0, quadMode, io2OeN}, 8'h03);
      check({5'h0, io2Out, io3Out, io3OeN}, 8'h01);
      for (int k = 0; k < 2; k++) begin
         host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
         // With the complement bit set only the top 64K block is open to change.
         host.xfer({(k == 1 ? CMD_ERASE_4K : CMD_PAGE_PROGRAM), 24'h7F0000, 8'h00},
                   (k == 1) ? 32 : 40);
         host.xfer({CMD_SUSPEND, 32'h0}, 8);
         rd(CMD_READ_SR2, v); check(v, (k == 1) ? 8'hC2 : 8'h46);
         host.xfer({CMD_RESUME, 32'h0}, 8);
         rd(CMD_READ_SR2, v); check(v, 8'h42);
         waitIdle();
      end
      host.xfer({CMD_WRITE_ENABLE, 32'h0}, 8);
      host.xfer({CMD_PAGE_PROGRAM, 32'h0}, 40);
      rd(CMD_READ_SR1, v); check(v, 8'h04);
      wr(CMD_WRITE_SR2, 8'h01);
      wr(CMD_WRITE_SR1, 8'h08);
      rd(CMD_READ_SR1, v); check(v, 8'h04);
      doReset();
      rd(CMD_READ_SR2, v); check(v, 8'h00);
      rd(CMD_READ_SR1, v); check(v, 8'h00);
      finishTest();
   end
endmodule : fsp_status_guard_bench
`default_nettype wire
